/* File: rtl/lcdsc_regs.vh */
// constants and rule summary for the lcd scan, cursor and character generator block
// What this block does
// - two-panel drive reads an upper and a lower line within one read cycle
// - every display memory read cycle lasts nine clock periods, longer while a nearly full fifo holds it at phase 0
// - read cycles per line equal characters-per-row plus one
// - reads pause total-row-length minus characters-per-row cycles; drive signals continue
// - the end-of-line pause is flagged so the host may access memory then
// - pause applies to both panels; line latch pulse only after lower panel
// - one cursor register is both cursor position and host access address
// - each memory access steps the cursor by the selected direction step
// - cursor only on first or third layer, hidden outside that layer
// - dummy graphics cursor only with graphics on, text off, host address
// - no text screen gives bar cursor; mixed layer block gives block on text
// - character hscroll via start address; pixel hscroll via its command value
// - pixel hscroll is one value shared by every screen block
// - external character rom at f000-f7ff short fonts, f000-ffff tall fonts
// - external rom holds at most 256 glyphs, unused glyph bits zero
// - character codes are 8 bits; ram banks of 64 glyphs via base
// - heights 1-8 short font, 9-16 tall font, taller drawn as graphics
// - short font address is base plus code at bits 10-3 plus row
// - tall font address is base plus code at bits 11-4 plus row
// - fold setting forces code bit 6 to zero for the second ram area
`ifndef LCDSC_REGS_VH
`define LCDSC_REGS_VH
`define LCDSC_READ_CYCLE_CLKS 4'd9
`define LCDSC_PHASE_LAST 4'd8
`define LCDSC_PHASE_UPPER 4'd0
`define LCDSC_PHASE_LOWER 4'd4
`define LCDSC_STEP_RIGHT 2'd0
`define LCDSC_STEP_LEFT 2'd1
`define LCDSC_STEP_UP 2'd2
`define LCDSC_STEP_DOWN 2'd3
`define LCDSC_EXT_ROM_BASE 16'hf000
`define LCDSC_EXT_ROM_END_SHORT 16'hf7ff
`define LCDSC_EXT_ROM_END_TALL 16'hffff
`define LCDSC_SHORT_ROW_MAX 4'h7
`define LCDSC_TALL_ROW_MAX 4'hf
`define LCDSC_CURSOR_RESET 16'h0000
`endif

/* File: rtl/lcdsc_scan.v */
// lcd display scan engine with cursor handling, glyph addressing and output fifo
`timescale 1ns/100ps
`default_nettype none
`include "lcdsc_regs.vh"

// small synchronous fifo; storage in flip-flops addressed by index
module lcdsc_fifo #(
    parameter W = 27,
    parameter D = 8,
    parameter AW = 3
) (
    input wire i_sys_clk,
    input wire i_reset_n,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [W-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [W-1:0] o_out_data,
    output wire [AW:0] o_count
);
    reg [W-1:0] mem_q [0:D-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;
    assign o_in_ready = (cnt_q != D[AW:0]);
    assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem_q[rd_q];
    assign o_count = cnt_q;

    // storage has no reset; only pointers and count are control state
    always @(posedge i_sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    // pointers wrap at the depth so depth need not be a power of two
    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

module lcdsc_scan #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    input wire i_sys_clk,
    input wire i_reset_n,
    input wire i_display_on,
    input wire i_two_panel,
    input wire i_text_mode,
    input wire [7:0] i_chars_per_row,
    input wire [7:0] i_total_row_length,
    input wire [8:0] i_lines_per_panel,
    input wire [3:0] i_font_rows_m1,
    input wire [7:0] i_address_pitch,
    input wire [15:0] i_scroll_start_addr_one,
    input wire [15:0] i_scroll_start_addr_three,
    input wire [2:0] i_pixel_hscroll_command,
    input wire i_cursor_load,
    input wire [15:0] i_cursor_load_addr,
    input wire [1:0] i_cursor_step_command,
    input wire i_host_mem_access,
    input wire i_three_layer,
    input wire [15:0] i_cursor_layer_start,
    input wire [15:0] i_cursor_layer_end,
    input wire i_text_on,
    input wire i_graphics_on,
    input wire i_dummy_cursor_en,
    input wire i_first_layer_mixed,
    input wire i_block_shape,
    input wire [15:0] i_cg_base_address,
    input wire i_cg_bit6_fold,
    input wire i_tall_font_select,
    input wire i_cg_source_select,
    input wire [7:0] i_vram_data,
    input wire i_disp_ready,
    output reg [15:0] o_vram_addr,
    output reg o_vram_rd,
    output reg o_line_latch_pulse,
    output reg o_frame_start,
    output reg o_host_window,
    output reg [15:0] o_cursor_addr,
    output reg [2:0] o_pixel_hscroll,
    output reg o_disp_valid,
    output reg [7:0] o_disp_data,
    output reg [15:0] o_disp_cg_addr,
    output reg o_disp_ext_rom,
    output reg o_disp_lower,
    output reg o_disp_cursor,
    output reg o_disp_cursor_block
);
    localparam FW = 28;

    // glyph address: base plus shifted code plus row, tall fonts one bit further
    function [15:0] lcdsc_cg_addr;
        input [15:0] base;
        input [7:0] code;
        input [3:0] row;
        input tall;
        input fold;
        reg [7:0] c;
        begin
            c = code;
            if (fold && code[7] && code[6]) begin
                c[6] = 1'b0;
            end
            if (tall) begin
                lcdsc_cg_addr = base + {4'h0, c, row};
            end else begin
                lcdsc_cg_addr = base + {5'h00, c, row[2:0]};
            end
        end
    endfunction

    reg [3:0] phase_q;
    reg [7:0] col_q;
    reg [3:0] row_q;
    reg [8:0] line_q;
    reg [15:0] upper_start_q;
    reg [15:0] lower_start_q;
    reg [15:0] cursor_q;
    reg rd_pend_q;
    reg rd_lower_q;
    reg rd_cursor_q;
    wire [FIFO_AW:0] fifo_count;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [FW-1:0] fifo_out_data;
    wire [FW-1:0] fifo_in_data;
    wire fifo_pop;
    wire reading_col;
    wire stall;
    wire line_end;
    wire row_wrap;
    wire [3:0] row_max;
    wire [15:0] upper_addr;
    wire [15:0] lower_addr;
    wire [15:0] fetch_addr;
    wire fetch_now;
    wire fetch_lower;
    wire cursor_in_layer;
    wire cursor_visible;
    wire [15:0] cg_addr;
    wire [15:0] ext_end;
    wire ext_rom;
    wire cursor_block;

    // two slots must be free before a cycle starts, since it may push two bytes
    assign stall = (phase_q == `LCDSC_PHASE_UPPER) &&
        (fifo_count > FIFO_DEPTH[FIFO_AW:0] - 2'd2);
    assign reading_col = (col_q <= i_chars_per_row);
    assign line_end = (phase_q == `LCDSC_PHASE_LAST) && (col_q == i_total_row_length);
    // tall font rows cap at 16, short at 8; taller glyphs belong to graphics mode
    assign row_max = i_tall_font_select ?
        ((i_font_rows_m1 > `LCDSC_TALL_ROW_MAX) ? `LCDSC_TALL_ROW_MAX : i_font_rows_m1) :
        ((i_font_rows_m1 > `LCDSC_SHORT_ROW_MAX) ? `LCDSC_SHORT_ROW_MAX : i_font_rows_m1);
    assign row_wrap = !i_text_mode || (row_q >= row_max);
    assign upper_addr = upper_start_q + {8'h00, col_q};
    assign lower_addr = lower_start_q + {8'h00, col_q};
    // upper read at phase 0, lower at phase 4 of the same nine-clock cycle
    assign fetch_now = i_display_on && reading_col && !stall &&
        ((phase_q == `LCDSC_PHASE_UPPER) ||
        (i_two_panel && (phase_q == `LCDSC_PHASE_LOWER)));
    assign fetch_lower = (phase_q == `LCDSC_PHASE_LOWER);
    assign fetch_addr = fetch_lower ? lower_addr : upper_addr;

    // cursor lives in layer one (two layers) or layer three; window given by host
    assign cursor_in_layer = (cursor_q >= i_cursor_layer_start) &&
        (cursor_q <= i_cursor_layer_end);
    assign cursor_visible = cursor_in_layer &&
        (i_text_on || (i_graphics_on && i_dummy_cursor_en));
    // without text only a bar; block only on text cells with two layers or a mixed first layer
    assign cursor_block = i_block_shape && i_text_on && i_text_mode &&
        (i_first_layer_mixed || !i_three_layer);

    assign cg_addr = lcdsc_cg_addr(i_cg_base_address, i_vram_data, row_q,
        i_tall_font_select, i_cg_bit6_fold);
    assign ext_end = i_tall_font_select ? `LCDSC_EXT_ROM_END_TALL : `LCDSC_EXT_ROM_END_SHORT;
    assign ext_rom = i_cg_source_select && i_text_mode &&
        (cg_addr >= `LCDSC_EXT_ROM_BASE) && (cg_addr <= ext_end);
    assign fifo_in_data = {cursor_block, rd_cursor_q, rd_lower_q, ext_rom,
        i_text_mode ? cg_addr : 16'h0000, i_vram_data};
    assign fifo_pop = fifo_out_valid && (!o_disp_valid || i_disp_ready);

    lcdsc_fifo #(
        .W(FW),
        .D(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_in_valid(rd_pend_q),
        .o_in_ready(fifo_in_ready),
        .i_in_data(fifo_in_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_out_data),
        .o_count(fifo_count)
    );

    // scan counters: phase within read cycle, column, glyph row and line
    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase_q <= 4'h0;
            col_q <= 8'h00;
            row_q <= 4'h0;
            line_q <= 9'h000;
            upper_start_q <= 16'h0000;
            lower_start_q <= 16'h0000;
            o_line_latch_pulse <= 1'b0;
            o_frame_start <= 1'b0;
            o_host_window <= 1'b0;
            o_pixel_hscroll <= 3'h0;
        end else begin
            o_line_latch_pulse <= 1'b0;
            o_frame_start <= 1'b0;
            // pause keeps counting so drive timing runs on while reads stop
            o_host_window <= !reading_col;
            if (!stall) begin
                if (phase_q == `LCDSC_PHASE_LAST) begin
                    phase_q <= 4'h0;
                end else begin
                    phase_q <= phase_q + 1'b1;
                end
            end
            if (phase_q == `LCDSC_PHASE_LAST) begin
                col_q <= line_end ? 8'h00 : col_q + 1'b1;
            end
            if (line_end) begin
                // one latch per line period, after the lower panel was read
                o_line_latch_pulse <= 1'b1;
                row_q <= row_wrap ? 4'h0 : row_q + 1'b1;
                if (line_q + 1'b1 >= i_lines_per_panel) begin
                    line_q <= 9'h000;
                    row_q <= 4'h0;
                    // new scroll starts take effect at frame start; no blanking here
                    upper_start_q <= i_scroll_start_addr_one;
                    lower_start_q <= i_scroll_start_addr_three;
                    o_frame_start <= 1'b1;
                    // one pixel offset for all blocks, latched once per frame
                    o_pixel_hscroll <= i_pixel_hscroll_command;
                end else begin
                    line_q <= line_q + 1'b1;
                    if (row_wrap) begin
                        upper_start_q <= upper_start_q + {8'h00, i_address_pitch};
                        lower_start_q <= lower_start_q + {8'h00, i_address_pitch};
                    end
                end
            end
        end
    end

    // memory read strobe and the tag that travels with its returning byte
    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_vram_addr <= 16'h0000;
            o_vram_rd <= 1'b0;
            rd_pend_q <= 1'b0;
            rd_lower_q <= 1'b0;
            rd_cursor_q <= 1'b0;
        end else begin
            o_vram_rd <= fetch_now;
            rd_pend_q <= fetch_now && fifo_in_ready;
            if (fetch_now) begin
                o_vram_addr <= fetch_addr;
                rd_lower_q <= fetch_lower;
                rd_cursor_q <= cursor_visible && (fetch_addr == cursor_q);
            end
        end
    end

    // one register is both cursor and access address; load beats stepping
    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cursor_q <= `LCDSC_CURSOR_RESET;
            o_cursor_addr <= `LCDSC_CURSOR_RESET;
        end else begin
            if (i_cursor_load) begin
                cursor_q <= i_cursor_load_addr;
                o_cursor_addr <= i_cursor_load_addr;
            end else if (i_host_mem_access) begin
                case (i_cursor_step_command)
                    `LCDSC_STEP_RIGHT: begin
                        cursor_q <= cursor_q + 16'h0001;
                        o_cursor_addr <= cursor_q + 16'h0001;
                    end
                    `LCDSC_STEP_LEFT: begin
                        cursor_q <= cursor_q - 16'h0001;
                        o_cursor_addr <= cursor_q - 16'h0001;
                    end
                    `LCDSC_STEP_UP: begin
                        cursor_q <= cursor_q - {8'h00, i_address_pitch};
                        o_cursor_addr <= cursor_q - {8'h00, i_address_pitch};
                    end
                    default: begin
                        cursor_q <= cursor_q + {8'h00, i_address_pitch};
                        o_cursor_addr <= cursor_q + {8'h00, i_address_pitch};
                    end
                endcase
            end
        end
    end

    // output stage keeps every display output on a flip-flop
    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_disp_valid <= 1'b0;
            o_disp_data <= 8'h00;
            o_disp_cg_addr <= 16'h0000;
            o_disp_ext_rom <= 1'b0;
            o_disp_lower <= 1'b0;
            o_disp_cursor <= 1'b0;
            o_disp_cursor_block <= 1'b0;
        end else if (!o_disp_valid || i_disp_ready) begin
            o_disp_valid <= fifo_out_valid;
            if (fifo_out_valid) begin
                o_disp_data <= fifo_out_data[7:0];
                o_disp_cg_addr <= fifo_out_data[23:8];
                o_disp_ext_rom <= fifo_out_data[24];
                o_disp_lower <= fifo_out_data[25];
                o_disp_cursor <= fifo_out_data[26];
                o_disp_cursor_block <= fifo_out_data[27] && fifo_out_data[26];
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/lcdsc_far_model.sv */
// display memory and pixel consumer model facing the scan block
`timescale 1ns/100ps
`default_nettype none
module lcdsc_far_model (
    input wire logic i_sys_clk,
    input wire logic i_vram_rd,
    input wire logic [15:0] i_vram_addr,
    input wire logic i_slow,
    output logic [7:0] o_vram_data,
    output logic o_disp_ready
);
    logic [4:0] tick_q = 5'h00;
    logic rd_q = 1'b0;
    // free tick drives the idle pattern and the slow accept rate
    always @(posedge i_sys_clk) begin
        tick_q <= tick_q + 5'h01;
        rd_q <= i_vram_rd;
    end
    // byte valid in the read cycle and the next; otherwise a moving pattern so stale data shows
    assign o_vram_data = (i_vram_rd || rd_q) ? (i_vram_addr[7:0] ^ 8'hc3) : {tick_q[3:0], ~tick_q[3:0]};
    // slow consumer takes one beat in 32 so the fifo backs up
    assign o_disp_ready = !i_slow || (tick_q == 5'h00);
endmodule
`default_nettype wire

/* File: verif/lcdsc_scan_checker.sv */
// assertion checker for the lcd scan, cursor and glyph address block
`timescale 1ns/100ps
`default_nettype none
module lcdsc_scan_checker (
    input wire i_sys_clk,
    input wire i_reset_n,
    input wire i_display_on,
    input wire i_two_panel,
    input wire i_text_mode,
    input wire [7:0] i_total_row_length,
    input wire [7:0] i_address_pitch,
    input wire i_cursor_load,
    input wire [15:0] i_cursor_load_addr,
    input wire [1:0] i_cursor_step_command,
    input wire i_host_mem_access,
    input wire [15:0] i_cg_base_address,
    input wire i_cg_bit6_fold,
    input wire i_tall_font_select,
    input wire i_cg_source_select,
    input wire i_disp_ready,
    input wire o_vram_rd,
    input wire o_line_latch_pulse,
    input wire o_frame_start,
    input wire o_host_window,
    input wire [15:0] o_cursor_addr,
    input wire o_disp_valid,
    input wire [7:0] o_disp_data,
    input wire [15:0] o_disp_cg_addr,
    input wire o_disp_ext_rom
);
    logic [11:0] gap_q;
    logic seen_q;
    logic [15:0] step_d, next_cur, cg_off;
    logic [7:0] code_eff;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    // clocks since the last latch pulse; a stall may only lengthen a line
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gap_q <= 12'h000;
            seen_q <= 1'b0;
        end else if (o_line_latch_pulse) begin
            gap_q <= 12'h001;
            seen_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 12'h001;
        end
    end
    // expected cursor after an access, and the glyph offset from the base
    always_comb begin
        case (i_cursor_step_command)
            2'h0: step_d = 16'h0001;
            2'h1: step_d = 16'hffff;
            2'h2: step_d = -{8'h00, i_address_pitch};
            default: step_d = {8'h00, i_address_pitch};
        endcase
        next_cur = o_cursor_addr + step_d;
        cg_off = o_disp_cg_addr - i_cg_base_address;
        code_eff = (i_cg_bit6_fold && o_disp_data[7:6] == 2'h3) ? (o_disp_data & 8'hbf) : o_disp_data;
    end
    sequence s_upper_rd;
        o_vram_rd && i_two_panel && !$past(o_vram_rd, 4);
    endsequence
    sequence s_lower_rd;
        ##4 o_vram_rd;
    endsequence
    property p_pair;
        s_upper_rd |-> s_lower_rd;
    endproperty
    a_pair: assert property (p_pair) else $error("lower panel read missing");
    property p_single_gap;
        o_vram_rd && !i_two_panel |=> !o_vram_rd [*8];
    endproperty
    a_single_gap: assert property (p_single_gap) else $error("read cycle too short");
    property p_off;
        !$past(i_display_on) |-> !o_vram_rd;
    endproperty
    a_off: assert property (p_off) else $error("read while display off");
    property p_window;
        o_host_window |-> !o_vram_rd;
    endproperty
    a_window: assert property (p_window) else $error("read inside line pause");
    property p_line_len;
        o_line_latch_pulse && seen_q |-> gap_q >= ({4'h0, i_total_row_length} + 12'h001) * 12'h009;
    endproperty
    a_line_len: assert property (p_line_len) else $error("line period too short");
    property p_frame;
        o_frame_start |-> o_line_latch_pulse;
    endproperty
    a_frame: assert property (p_frame) else $error("frame start without latch");
    property p_load;
        i_cursor_load |=> o_cursor_addr == $past(i_cursor_load_addr);
    endproperty
    a_load: assert property (p_load) else $error("cursor load lost");
    property p_step;
        i_host_mem_access && !i_cursor_load |=> o_cursor_addr == $past(next_cur);
    endproperty
    a_step: assert property (p_step) else $error("cursor step wrong");
    property p_stand;
        o_disp_valid && !i_disp_ready |=> o_disp_valid && $stable(o_disp_data) && $stable(o_disp_cg_addr);
    endproperty
    a_stand: assert property (p_stand) else $error("display beat changed while held");
    property p_cg;
        o_disp_valid && i_text_mode |->
            (i_tall_font_select ? cg_off[15:4] == {4'h0, code_eff} : cg_off[15:3] == {5'h00, code_eff});
    endproperty
    a_cg: assert property (p_cg) else $error("glyph address wrong");
    property p_ext;
        o_disp_valid && o_disp_ext_rom |-> i_cg_source_select && o_disp_cg_addr[15:12] == 4'hf
            && (i_tall_font_select || !o_disp_cg_addr[11]);
    endproperty
    a_ext: assert property (p_ext) else $error("rom flag outside rom range");
endmodule
bind lcdsc_scan lcdsc_scan_checker u_chk (.i_sys_clk, .i_reset_n, .i_display_on, .i_two_panel,
    .i_text_mode, .i_total_row_length, .i_address_pitch, .i_cursor_load, .i_cursor_load_addr,
    .i_cursor_step_command, .i_host_mem_access, .i_cg_base_address, .i_cg_bit6_fold,
    .i_tall_font_select, .i_cg_source_select, .i_disp_ready, .o_vram_rd, .o_line_latch_pulse,
    .o_frame_start, .o_host_window, .o_cursor_addr, .o_disp_valid, .o_disp_data,
    .o_disp_cg_addr, .o_disp_ext_rom);
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the lcd scan, cursor and glyph address block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
    logic i_sys_clk = 1'b0, i_reset_n = 1'b0, i_display_on = 1'b0, i_two_panel = 1'b0;
    logic i_text_mode = 1'b1, i_slow = 1'b0, i_cursor_load = 1'b0, i_host_mem_access = 1'b0;
    logic i_three_layer = 1'b0, i_text_on = 1'b1, i_graphics_on = 1'b1, i_dummy_cursor_en = 1'b1;
    logic i_first_layer_mixed = 1'b0, i_block_shape = 1'b0, i_cg_bit6_fold = 1'b0;
    logic i_tall_font_select = 1'b0, i_cg_source_select = 1'b0;
    logic [7:0] i_chars_per_row = 8'h03, i_total_row_length = 8'h05, i_address_pitch = 8'h40;
    logic [8:0] i_lines_per_panel = 9'h010;
    logic [3:0] i_font_rows_m1 = 4'h7;
    logic [15:0] i_scroll_start_addr_one = 16'h0000, i_scroll_start_addr_three = 16'h0000;
    logic [15:0] i_cursor_load_addr = 16'h1234, i_cursor_layer_start = 16'h0000;
    logic [15:0] i_cursor_layer_end = 16'h00ff, i_cg_base_address = 16'hf000;
    logic [2:0] i_pixel_hscroll_command = 3'h0;
    logic [1:0] i_cursor_step_command = 2'h0;
    wire logic [7:0] i_vram_data, o_disp_data;
    wire logic i_disp_ready, o_vram_rd, o_line_latch_pulse, o_frame_start, o_host_window;
    wire logic o_disp_valid, o_disp_ext_rom, o_disp_lower, o_disp_cursor, o_disp_cursor_block;
    wire logic [15:0] o_vram_addr, o_cursor_addr, o_disp_cg_addr;
    wire logic [2:0] o_pixel_hscroll;
    int error_cnt = 0, num_checks = 0, n_rd, n_win, n_clk, n_cur, n_blk, k;
    lcdsc_scan u_dut (.i_sys_clk, .i_reset_n, .i_display_on, .i_two_panel, .i_text_mode,
        .i_chars_per_row, .i_total_row_length, .i_lines_per_panel, .i_font_rows_m1,
        .i_address_pitch, .i_scroll_start_addr_one, .i_scroll_start_addr_three,
        .i_pixel_hscroll_command, .i_cursor_load, .i_cursor_load_addr, .i_cursor_step_command,
        .i_host_mem_access, .i_three_layer, .i_cursor_layer_start, .i_cursor_layer_end,
        .i_text_on, .i_graphics_on, .i_dummy_cursor_en, .i_first_layer_mixed, .i_block_shape,
        .i_cg_base_address, .i_cg_bit6_fold, .i_tall_font_select, .i_cg_source_select,
        .i_vram_data, .i_disp_ready, .o_vram_addr, .o_vram_rd, .o_line_latch_pulse,
        .o_frame_start, .o_host_window, .o_cursor_addr, .o_pixel_hscroll, .o_disp_valid,
        .o_disp_data, .o_disp_cg_addr, .o_disp_ext_rom, .o_disp_lower, .o_disp_cursor,
        .o_disp_cursor_block);
    lcdsc_far_model u_far (.i_sys_clk, .i_vram_rd(o_vram_rd), .i_vram_addr(o_vram_addr),
        .i_slow, .o_vram_data(i_vram_data), .o_disp_ready(i_disp_ready));
    // 250 mhz system clock
    always #2 i_sys_clk = ~i_sys_clk;
    task automatic give_verdict;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // a spent wait bound counts as a mismatch and ends the run
    task automatic bound_hit;
        if (k >= 4000) begin
            error_cnt++;
            give_verdict;
        end
    endtask
    // tally one whole line, latch to latch
    task automatic measure_line;
        k = 0;
        do begin
            @(negedge i_sys_clk);
            k++;
        end while (!o_line_latch_pulse && k < 4000);
        bound_hit;
        n_rd = 0; n_win = 0; n_clk = 0; n_cur = 0; n_blk = 0;
        do begin
            @(negedge i_sys_clk);
            n_clk++;
            n_rd += o_vram_rd;
            n_win += o_host_window;
            n_cur += o_disp_valid && i_disp_ready && o_disp_cursor;
            n_blk += o_disp_valid && i_disp_ready && o_disp_cursor && o_disp_cursor_block;
        end while (!o_line_latch_pulse && n_clk < 4000);
        k = n_clk;
        bound_hit;
    endtask
    task automatic wait_frame;
        for (k = 0; k < 4000 && !o_frame_start; k++) @(negedge i_sys_clk);
        bound_hit;
    endtask
    task automatic t_scan;
        i_display_on = 1'b1;
        measure_line;
        `CHK("line clocks", 54, n_clk)
        `CHK("reads per line", 4, n_rd)
        `CHK("pause clocks", 18, n_win)
        i_display_on = 1'b0;
        measure_line;
        measure_line;
        `CHK("reads when off", 0, n_rd)
        `CHK("clocks when off", 54, n_clk)
        i_display_on = 1'b1;
    endtask
    task automatic t_two;
        i_two_panel = 1'b1;
        measure_line;
        measure_line;
        `CHK("two panel reads", 8, n_rd)
        `CHK("two panel clocks", 54, n_clk)
        i_two_panel = 1'b0;
    endtask
    // back-to-back cursor operations, one per clock
    task automatic step_cursor(input logic ld, input logic [1:0] dir, input logic [15:0] exp);
        i_cursor_load = ld;
        i_host_mem_access = 1'b1;
        i_cursor_step_command = dir;
        @(negedge i_sys_clk);
        `CHK("cursor", exp, o_cursor_addr)
    endtask
    task automatic t_cursor;
        step_cursor(1'b1, 2'h0, 16'h1234);
        step_cursor(1'b0, 2'h0, 16'h1235);
        step_cursor(1'b0, 2'h1, 16'h1234);
        step_cursor(1'b0, 2'h2, 16'h11f4);
        step_cursor(1'b0, 2'h3, 16'h1234);
        i_cursor_load_addr = 16'h0002;
        step_cursor(1'b1, 2'h3, 16'h0002);
        i_cursor_load = 1'b0;
        i_host_mem_access = 1'b0;
    endtask
    // cursor sits on address 2, read once per scan line of the first text row
    task automatic t_show;
        i_block_shape = 1'b1;
        wait_frame;
        measure_line;
        `CHK("cursor beats", 1, n_cur)
        `CHK("block beats", 1, n_blk)
        i_text_on = 1'b0;
        wait_frame;
        measure_line;
        `CHK("bar beats", 0, n_blk)
        i_text_on = 1'b1;
        i_cursor_layer_start = 16'h0010;
        wait_frame;
        measure_line;
        `CHK("hidden cursor", 0, n_cur)
        i_cursor_layer_start = 16'h0000;
    endtask
    // slow consumer fills the fifo; reads stall, none lost
    task automatic t_stall;
        i_two_panel = 1'b1;
        i_slow = 1'b1;
        repeat (3) measure_line;
        `CHK("stalled reads", 8, n_rd)
        `CHK("stall lengthens", 1'b1, n_clk > 54)
        i_slow = 1'b0;
        i_two_panel = 1'b0;
        repeat (3) measure_line;
    endtask
    // settings change only with the pipe drained
    task automatic t_cg;
        logic [7:0] code;
        logic [15:0] mask;
        for (int i = 0; i < 4; i++) begin
            i_display_on = 1'b0;
            measure_line;
            i_tall_font_select = i[0];
            i_cg_bit6_fold = i[1];
            i_cg_source_select = i[1];
            i_display_on = 1'b1;
            measure_line;
            for (k = 0; k < 4000 && !(o_disp_valid && i_disp_ready); k++) @(negedge i_sys_clk);
            bound_hit;
            code = (i[1] && o_disp_data[7:6] == 2'h3) ? (o_disp_data & 8'hbf) : o_disp_data;
            mask = i[0] ? 16'h000f : 16'h0007;
            `CHK("glyph", 16'hf000 + (i[0] ? {4'h0, code, 4'h0} : {5'h00, code, 3'h0}), o_disp_cg_addr & ~mask)
            `CHK("rom flag", i[1] & (i[0] | ~o_disp_cg_addr[11]), o_disp_ext_rom)
        end
    endtask
    task automatic t_hscroll;
        wait_frame;
        @(negedge i_sys_clk);
        i_pixel_hscroll_command = 3'h5;
        i_scroll_start_addr_one = 16'h0040;
        repeat (3) @(negedge i_sys_clk);
        `CHK("hscroll mid frame", 3'h0, o_pixel_hscroll)
        wait_frame;
        repeat (2) @(negedge i_sys_clk);
        `CHK("hscroll", 3'h5, o_pixel_hscroll)
        `CHK("scroll start", 16'h0040, o_vram_addr)
    endtask
    initial begin
        repeat (5) @(negedge i_sys_clk);
        i_reset_n = 1'b1;
        t_scan;
        t_two;
        t_cursor;
        t_show;
        t_stall;
        t_cg;
        t_hscroll;
        give_verdict;
    end
endmodule
`default_nettype wire
